// ===== rtl/thermal_pkg.sv
// constants shared by the thermal pin timer and trip block
package thermal_pkg;

    // ------------------------------------------------------------
    // bus and structure widths
    // ------------------------------------------------------------
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 8;
    localparam int CHANNELS   = 3;
    localparam int FANS       = 3;
    localparam int TEMP_W     = 10;
    localparam int PRESCALE_W = 22;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS_SECOND    = 8'h42;
    localparam logic [7:0] OFS_REMOTE1_CFG      = 8'h5F;
    localparam logic [7:0] OFS_LOCAL_CFG        = 8'h60;
    localparam logic [7:0] OFS_REMOTE2_CFG      = 8'h61;
    localparam logic [7:0] OFS_REMOTE1_CRIT     = 8'h6A;
    localparam logic [7:0] OFS_LOCAL_CRIT       = 8'h6B;
    localparam logic [7:0] OFS_REMOTE2_CRIT     = 8'h6C;
    localparam logic [7:0] OFS_ALERT_MASK_2     = 8'h75;
    localparam logic [7:0] OFS_CONFIG_THIRD     = 8'h78;
    localparam logic [7:0] OFS_TIMER_COUNTER    = 8'h79;
    localparam logic [7:0] OFS_TIMER_LIMIT      = 8'h7A;
    localparam logic [7:0] OFS_TEMP_FORMAT      = 8'h7C;
    localparam logic [7:0] OFS_CONFIG_FOURTH    = 8'h7D;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CFG3_THERMAL_EVENT_PIN_EN_BIT = 1;
    localparam int CFG3_BOOST_BIT    = 2;
    localparam int CH_THERMAL_EVENT_PIN_OUT_BIT  = 3;
    localparam int STATUS2_F4P_BIT   = 5;
    localparam int MASK2_F4P_BIT     = 5;
    localparam int FMT_OFFSET_BIT    = 0;

    // ------------------------------------------------------------
    // shared pin function codes (field value of config_fourth[1:0])
    // ------------------------------------------------------------
    localparam logic [1:0] PIN_FN_TACH    = 2'h0;
    localparam logic [1:0] PIN_FN_ALERT   = 2'h1;
    localparam logic [1:0] PIN_FN_THERMAL = 2'h2;
    localparam logic [1:0] PIN_FN_GPIO    = 2'h3;

    // ------------------------------------------------------------
    // values after reset and special codes
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_RESET          = 8'h00;
    localparam logic [7:0] CRIT_RESET         = 8'h7F;
    localparam logic [7:0] LIMIT_RESET        = 8'h00;
    localparam logic [7:0] TIMER_FULL         = 8'hFF;
    localparam logic [7:0] TIMER_LSB_STEPS    = 8'h02;
    localparam logic [7:0] CRIT_OFF_OFFSET    = 8'h00;
    localparam logic [7:0] CRIT_OFF_TWOS      = 8'h80;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS     = 8;
    localparam int STEP_TIME_NS        = 22760000;
    localparam int STEP_CYCLES_DEFAULT = STEP_TIME_NS / CLOCK_PERIOD_NS;

endpackage : thermal_pkg

// ===== rtl/thermal_pin_timer_and_trip.sv
// thermal event pin: function select, assertion timer, limit flag, alert, boost, trip
module thermal_pin_timer_and_trip
    import thermal_pkg::*;
#(
    parameter int STEP_CYCLES = STEP_CYCLES_DEFAULT
) (
    // clock and reset
    input  wire logic                           clock,
    input  wire logic                           rst_n,
    // register port
    input  wire logic [ADDR_W-1:0]              reg_addr,
    input  wire logic [DATA_W-1:0]              reg_wdata,
    input  wire logic                           reg_write,
    input  wire logic                           reg_read,
    output logic      [DATA_W-1:0]              reg_rdata,
    // dedicated thermal event pin (open drain)
    input  wire logic                           thermal_event_pin_in,
    output logic                                thermal_event_pin_out,
    output logic                                thermal_event_pin_oe,
    // shared pin (open drain)
    input  wire logic                           shared_pin_in,
    output logic                                shared_pin_out,
    output logic                                shared_pin_oe,
    // pin role indications
    output logic                                supply_sense_select,
    output logic                                fan4_tach_input_select,
    output logic                                shared_gpio_select,
    // temperature measurements
    input  wire logic [CHANNELS-1:0][TEMP_W-1:0] temp_value,
    input  wire logic [CHANNELS-1:0]            temp_valid,
    // fan control
    input  wire logic [FANS-1:0]                fan_running,
    input  wire logic                           fan4_underspeed,
    output logic      [FANS-1:0]                fan_boost,
    // alert
    output logic                                alert_n
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CHANNELS-1:0][7:0]  ch_cfg;
        logic [CHANNELS-1:0][7:0]  crit;
        logic [7:0]                mask2;
        logic [7:0]                cfg3;
        logic [7:0]                cfg4;
        logic [7:0]                limit;
        logic [7:0]                fmt;
        logic [1:0]                pin20_sync;
        logic [1:0]                shared_sync;
        logic [PRESCALE_W-1:0]     prescale;
        logic [7:0]                steps;
        logic                      seen;
        logic                      f4p;
        logic                      alert;
        logic [CHANNELS-1:0]       trip;
        logic [FANS-1:0]           boost;
        logic [DATA_W-1:0]         rdata;
    } state_s;

    state_s state;
    state_s next_state;

    logic [PRESCALE_W-1:0] step_last;
    logic                  thermal_event_pin_en;
    logic                  shared_thermal;
    logic                  input_active;
    logic                  timer_read;
    logic                  status_read;
    logic [7:0]            timer_value;
    logic                  over_limit;
    logic                  f4p_cond;
    logic [CHANNELS-1:0]   next_trip;

    assign step_last = PRESCALE_W'(STEP_CYCLES - 1);

    // ------------------------------------------------------------
    // pin role decode
    // ------------------------------------------------------------
    // enable resets clear
    assign thermal_event_pin_en = state.cfg3[CFG3_THERMAL_EVENT_PIN_EN_BIT];
    assign shared_thermal = thermal_event_pin_en && (state.cfg4[1:0] == PIN_FN_THERMAL);
    assign supply_sense_select    = !thermal_event_pin_en;
    assign fan4_tach_input_select = (state.cfg4[1:0] == PIN_FN_TACH);
    assign shared_gpio_select     = (state.cfg4[1:0] == PIN_FN_GPIO);

    assign input_active = (thermal_event_pin_en && !state.pin20_sync[1])
                       || (shared_thermal && !state.shared_sync[1]);

    assign timer_read  = reg_read && (reg_addr == OFS_TIMER_COUNTER);
    assign status_read = reg_read && (reg_addr == OFS_STATUS_SECOND);

    always_comb begin
        if (state.steps >= TIMER_LSB_STEPS) begin
            timer_value = state.steps;
        end else begin
            timer_value = {7'h00, state.seen};
        end
    end

    assign over_limit = thermal_event_pin_en && (timer_value > state.limit);
    assign f4p_cond = thermal_event_pin_en ? over_limit
                    : (fan4_tach_input_select && fan4_underspeed);

    // ------------------------------------------------------------
    // critical trip per channel
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_trip
            logic              offset_mode;
            logic              limit_off;
            logic [TEMP_W-1:0] lim_ext;
            logic              above;
            assign offset_mode = state.fmt[FMT_OFFSET_BIT];
            assign limit_off = offset_mode ? (state.crit[ch] <= CRIT_OFF_OFFSET)
                                           : (state.crit[ch] == CRIT_OFF_TWOS);
            assign lim_ext = {state.crit[ch], 2'b00};
            assign above = offset_mode ? (temp_value[ch] > lim_ext)
                                       : ($signed(temp_value[ch]) > $signed(lim_ext));
            always_comb begin
                next_trip[ch] = state.trip[ch];
                if (!state.ch_cfg[ch][CH_THERMAL_EVENT_PIN_OUT_BIT] || limit_off) begin
                    next_trip[ch] = 1'b0;
                end else if (temp_valid[ch]) begin
                    next_trip[ch] = above;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;

        next_state.pin20_sync  = {state.pin20_sync[0], thermal_event_pin_in};
        next_state.shared_sync = {state.shared_sync[0], shared_pin_in};

        // register writes
        if (reg_write) begin
            case (reg_addr)
                OFS_REMOTE1_CFG:   next_state.ch_cfg[0] = reg_wdata;
                OFS_LOCAL_CFG:     next_state.ch_cfg[1] = reg_wdata;
                OFS_REMOTE2_CFG:   next_state.ch_cfg[2] = reg_wdata;
                OFS_REMOTE1_CRIT:  next_state.crit[0]   = reg_wdata;
                OFS_LOCAL_CRIT:    next_state.crit[1]   = reg_wdata;
                OFS_REMOTE2_CRIT:  next_state.crit[2]   = reg_wdata;
                OFS_ALERT_MASK_2:  next_state.mask2     = reg_wdata;
                OFS_CONFIG_THIRD:  next_state.cfg3      = reg_wdata;
                OFS_TIMER_LIMIT:   next_state.limit     = reg_wdata;
                OFS_TEMP_FORMAT:   next_state.fmt       = reg_wdata;
                OFS_CONFIG_FOURTH: next_state.cfg4      = reg_wdata;
                default:           next_state.mask2     = state.mask2;
            endcase
        end

        if (timer_read) begin
            next_state.prescale = '0;
            next_state.steps    = 8'h00;
            next_state.seen     = input_active;
        end else if (input_active) begin
            next_state.seen = 1'b1;
            if (state.prescale == step_last) begin
                next_state.prescale = '0;
                if (state.steps != TIMER_FULL) begin
                    next_state.steps = state.steps + 8'h01;
                end
            end else begin
                next_state.prescale = state.prescale + PRESCALE_W'(1);
            end
        end

        if (f4p_cond) begin
            next_state.f4p = 1'b1;
        end else if (status_read) begin
            next_state.f4p = 1'b0;
        end

        next_state.alert = (next_state.f4p || f4p_cond) && !state.mask2[MASK2_F4P_BIT];

        next_state.trip = next_trip;

        next_state.boost = (state.cfg3[CFG3_BOOST_BIT] && input_active)
                         ? fan_running : '0;

        // read data
        next_state.rdata = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                OFS_STATUS_SECOND: next_state.rdata = {2'b00, state.f4p, 5'b00000};
                OFS_REMOTE1_CFG:   next_state.rdata = state.ch_cfg[0];
                OFS_LOCAL_CFG:     next_state.rdata = state.ch_cfg[1];
                OFS_REMOTE2_CFG:   next_state.rdata = state.ch_cfg[2];
                OFS_REMOTE1_CRIT:  next_state.rdata = state.crit[0];
                OFS_LOCAL_CRIT:    next_state.rdata = state.crit[1];
                OFS_REMOTE2_CRIT:  next_state.rdata = state.crit[2];
                OFS_ALERT_MASK_2:  next_state.rdata = state.mask2;
                OFS_CONFIG_THIRD:  next_state.rdata = state.cfg3;
                OFS_TIMER_COUNTER: next_state.rdata = timer_value;
                OFS_TIMER_LIMIT:   next_state.rdata = state.limit;
                OFS_TEMP_FORMAT:   next_state.rdata = state.fmt;
                OFS_CONFIG_FOURTH: next_state.rdata = state.cfg4;
                default:           next_state.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state.ch_cfg      <= {CHANNELS{CFG_RESET}};
            state.crit        <= {CHANNELS{CRIT_RESET}};
            state.mask2       <= CFG_RESET;
            state.cfg3        <= CFG_RESET;
            state.cfg4        <= CFG_RESET;
            state.limit       <= LIMIT_RESET;
            state.fmt         <= CFG_RESET;
            state.pin20_sync  <= 2'b11;
            state.shared_sync <= 2'b11;
            state.prescale    <= '0;
            state.steps       <= 8'h00;
            state.seen        <= 1'b0;
            state.f4p         <= 1'b0;
            state.alert       <= 1'b0;
            state.trip        <= '0;
            state.boost       <= '0;
            state.rdata       <= 8'h00;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata = state.rdata;
    assign fan_boost = state.boost;
    assign alert_n   = !state.alert;

    assign thermal_event_pin_out = 1'b0;
    assign thermal_event_pin_oe  = thermal_event_pin_en && (|state.trip);
    assign shared_pin_out        = 1'b0;
    assign shared_pin_oe = (shared_thermal && (|state.trip))
                        || ((state.cfg4[1:0] == PIN_FN_ALERT) && state.alert);

endmodule : thermal_pin_timer_and_trip

// ===== tb/thermal_pin_timer_and_trip_properties.sv
// port-level checks for the thermal pin timer and trip block
module thermal_pin_timer_and_trip_properties
    import thermal_pkg::*;
#(
    parameter int STEP_CYCLES = STEP_CYCLES_DEFAULT
) (
    // clock, reset and register port
    input wire logic              clock,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_write,
    input wire logic              reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    // pins
    input wire logic              thermal_event_pin_in,
    input wire logic              thermal_event_pin_out,
    input wire logic              thermal_event_pin_oe,
    input wire logic              shared_pin_in,
    input wire logic              shared_pin_out,
    // roles, measurements, fans, alert
    input wire logic              fan4_tach_input_select,
    input wire logic              shared_gpio_select,
    input wire logic [CHANNELS-1:0] temp_valid,
    input wire logic [FANS-1:0]   fan_running,
    input wire logic [FANS-1:0]   fan_boost,
    input wire logic              alert_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // cycles since either pin was last seen low
    logic [2:0] idle_cnt;
    always_ff @(posedge clock) begin
        if (!rst_n || !thermal_event_pin_in || !shared_pin_in) begin
            idle_cnt <= 3'h0;
        end else if (idle_cnt != 3'h7) begin
            idle_cnt <= idle_cnt + 3'h1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_rdata_idle; !reg_read |=> reg_rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
    property p_status_bits;
        reg_read && reg_addr == OFS_STATUS_SECOND |=> (reg_rdata & 8'hDF) == 8'h00;
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("status extra bits");
    property p_open_drain; !thermal_event_pin_out && !shared_pin_out; endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin drives high");
    property p_role_onehot; !(fan4_tach_input_select && shared_gpio_select); endproperty
    a_role_onehot: assert property (p_role_onehot) else $error("two pin roles");
    property p_boost_running; |fan_boost |-> (fan_boost & ~$past(fan_running)) == 3'h0; endproperty
    a_boost_running: assert property (p_boost_running) else $error("boost on idle fan");
    property p_boost_pin; |fan_boost |-> idle_cnt < 3'h5; endproperty
    a_boost_pin: assert property (p_boost_pin) else $error("boost without pin low");
    property p_alert_hold;
        !alert_n && !reg_write && !$past(reg_write) && !(reg_read && reg_addr == OFS_STATUS_SECOND)
        && !$past(reg_read && reg_addr == OFS_STATUS_SECOND) |=> !alert_n;
    endproperty
    a_alert_hold: assert property (p_alert_hold) else $error("alert released early");
    property p_oe_cause;
        $changed(thermal_event_pin_oe) |-> $past(|temp_valid) || $past(|temp_valid, 2)
        || $past(reg_write) || $past(reg_write, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("trip changed between samples");
endmodule // thermal_pin_timer_and_trip_properties

bind thermal_pin_timer_and_trip thermal_pin_timer_and_trip_properties #(
    .STEP_CYCLES(STEP_CYCLES)
) props (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .thermal_event_pin_in(thermal_event_pin_in),
    .thermal_event_pin_out(thermal_event_pin_out), .thermal_event_pin_oe(thermal_event_pin_oe),
    .shared_pin_in(shared_pin_in), .shared_pin_out(shared_pin_out),
    .fan4_tach_input_select(fan4_tach_input_select), .shared_gpio_select(shared_gpio_select),
    .temp_valid(temp_valid), .fan_running(fan_running), .fan_boost(fan_boost), .alert_n(alert_n)
);

// ===== tb/cpu_hot_model.sv
// far-side hot signal pulling an open-drain pin that has a pull-up
module cpu_hot_model (
    // clock
    input wire logic clock,
    // pin
    input wire logic dut_oe,
    output logic     pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hot_req = 1'b0;
    // wired low from either party, high by pull-up otherwise
    assign pin_level = ~(hot_req | dut_oe);
    task automatic hold(input int n);
        @(posedge clock);
        hot_req <= 1'b1;
        repeat (n) @(posedge clock);
        hot_req <= 1'b0;
    endtask
endmodule // cpu_hot_model

// ===== tb/thermal_pin_timer_and_trip_bench.sv
// self-checking bench for the thermal pin timer and trip block
module thermal_pin_timer_and_trip_bench
    import thermal_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [CHANNELS-1:0][TEMP_W-1:0] temp_value = '0;
    logic [CHANNELS-1:0] temp_valid = 3'h0;
    logic [FANS-1:0] fan_running = 3'h0;
    logic fan4_underspeed = 1'b0;
    logic [7:0] reg_rdata;
    logic thermal_event_pin_in, thermal_event_pin_oe, shared_pin_in, shared_pin_oe;
    logic supply_sense_select, fan4_tach_input_select, shared_gpio_select, alert_n;
    logic [FANS-1:0] fan_boost;
    int mismatches = 0;
    int samples_checked = 0;
    always #4 clock = ~clock;

    thermal_pin_timer_and_trip #(.STEP_CYCLES(4)) dut (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .thermal_event_pin_in(thermal_event_pin_in), .thermal_event_pin_out(),
        .thermal_event_pin_oe(thermal_event_pin_oe), .shared_pin_in(shared_pin_in),
        .shared_pin_out(), .shared_pin_oe(shared_pin_oe),
        .supply_sense_select(supply_sense_select), .fan4_tach_input_select(fan4_tach_input_select),
        .shared_gpio_select(shared_gpio_select), .temp_value(temp_value), .temp_valid(temp_valid),
        .fan_running(fan_running), .fan4_underspeed(fan4_underspeed), .fan_boost(fan_boost),
        .alert_n(alert_n)
    );
    cpu_hot_model hot_main (.clock(clock), .dut_oe(thermal_event_pin_oe),
                            .pin_level(thermal_event_pin_in));
    cpu_hot_model hot_shared (.clock(clock), .dut_oe(shared_pin_oe), .pin_level(shared_pin_in));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        if (what != "") check(what, reg_rdata, exp);
    endtask
    task automatic boost_try(input logic [2:0] exp);
        fork
            hot_main.hold(20);
            begin
                idle(12);
                check("fan_boost", {5'h00, fan_boost}, {5'h00, exp});
            end
        join
    endtask
    task automatic trip(input logic [9:0] t, input logic exp, input int c = 0);
        @(posedge clock);
        temp_value[c] <= t;
        temp_valid[c] <= 1'b1;
        @(posedge clock);
        temp_valid[c] <= 1'b0;
        idle(4);
        check("trip_oe", {7'h00, thermal_event_pin_oe}, {7'h00, exp});
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        results();
    end

    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rd(OFS_CONFIG_THIRD, CFG_RESET, "cfg3");
        rd(OFS_REMOTE1_CRIT, CRIT_RESET, "crit1");
        rd(8'h01, 8'h00, "unmapped");
        check("alert_n", {7'h00, alert_n}, 8'h01);
        check("supply_sel", {7'h00, supply_sense_select}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CONFIG_FOURTH, 8'(i));
            idle(0);
            check("tach_sel", {7'h00, fan4_tach_input_select}, {7'h00, i == 0});
            check("gpio_sel", {7'h00, shared_gpio_select}, {7'h00, i == 3});
        end
        wr(OFS_CONFIG_FOURTH, {6'h00, PIN_FN_THERMAL});
        hot_shared.hold(20);
        hot_main.hold(20);
        rd(OFS_TIMER_COUNTER, 8'h00, "timer_off");
        $display("test roles done");
        wr(OFS_TIMER_LIMIT, 8'hFF);
        wr(OFS_CONFIG_THIRD, 8'h02);
        idle(0);
        check("supply_sel", {7'h00, supply_sense_select}, 8'h00);
        hot_main.hold(3);
        idle(5);
        rd(OFS_TIMER_COUNTER, 8'h01, "timer_first");
        hot_shared.hold(38);
        idle(5);
        rd(OFS_TIMER_COUNTER, 8'h09, "timer_steps");
        hot_main.hold(38);
        idle(5);
        hot_main.hold(20);
        idle(5);
        rd(OFS_TIMER_COUNTER, 8'h0E, "timer_sum");
        rd(OFS_TIMER_COUNTER, 8'h00, "timer_clear");
        hot_main.hold(1100);
        idle(5);
        rd(OFS_TIMER_COUNTER, TIMER_FULL, "timer_full");
        fork
            hot_main.hold(60);
            begin
                idle(20);
                rd(OFS_TIMER_COUNTER, 8'h00, "");
                rd(OFS_TIMER_COUNTER, 8'h01, "timer_reread");
            end
        join
        idle(5);
        rd(OFS_TIMER_COUNTER, 8'h00, "");
        $display("test timer done");
        wr(OFS_TIMER_LIMIT, 8'h01);
        rd(OFS_STATUS_SECOND, 8'h00, "status_idle");
        hot_main.hold(6);
        idle(5);
        check("alert_n", {7'h00, alert_n}, 8'h01);
        hot_main.hold(4);
        idle(5);
        check("alert_n", {7'h00, alert_n}, 8'h00);
        rd(OFS_STATUS_SECOND, 8'h20, "status_set");
        rd(OFS_STATUS_SECOND, 8'h20, "status_cause");
        rd(OFS_TIMER_COUNTER, 8'h02, "timer_two");
        rd(OFS_STATUS_SECOND, 8'h20, "status_last");
        rd(OFS_STATUS_SECOND, 8'h00, "status_clear");
        idle(2);
        check("alert_n", {7'h00, alert_n}, 8'h01);
        wr(OFS_TIMER_LIMIT, 8'h00);
        wr(OFS_ALERT_MASK_2, 8'h20);
        hot_main.hold(3);
        idle(5);
        check("alert_n", {7'h00, alert_n}, 8'h01);
        rd(OFS_TIMER_COUNTER, 8'h01, "timer_one");
        rd(OFS_STATUS_SECOND, 8'h20, "status_masked");
        wr(OFS_ALERT_MASK_2, 8'h00);
        $display("test limit done");
        wr(OFS_TIMER_LIMIT, 8'hFF);
        wr(OFS_CONFIG_THIRD, 8'h06);
        fan_running <= 3'h5;
        boost_try(3'h5);
        wr(OFS_CONFIG_THIRD, 8'h02);
        boost_try(3'h0);
        $display("test boost done");
        wr(OFS_REMOTE1_CRIT, 8'h50);
        wr(OFS_REMOTE1_CFG, 8'h08);
        trip(10'h141, 1'b1);
        temp_value[0] <= 10'h140;
        idle(6);
        check("trip_hold", {7'h00, thermal_event_pin_oe}, 8'h01);
        trip(10'h140, 1'b0);
        wr(OFS_REMOTE1_CRIT, CRIT_OFF_TWOS);
        trip(10'h141, 1'b0);
        wr(OFS_REMOTE1_CRIT, 8'h50);
        wr(OFS_REMOTE1_CFG, 8'h00);
        trip(10'h141, 1'b0);
        wr(OFS_TEMP_FORMAT, 8'h01);
        wr(OFS_LOCAL_CRIT, CRIT_OFF_OFFSET);
        wr(OFS_LOCAL_CFG, 8'h08);
        trip(10'h3FF, 1'b0, 1);
        wr(OFS_LOCAL_CRIT, 8'h50);
        trip(10'h141, 1'b1, 1);
        trip(10'h140, 1'b0, 1);
        wr(OFS_REMOTE2_CRIT, 8'h50);
        wr(OFS_REMOTE2_CFG, 8'h08);
        trip(10'h141, 1'b1, 2);
        check("shared_oe", {7'h00, shared_pin_oe}, 8'h01);
        trip(10'h140, 1'b0, 2);
        $display("test trip done");
        wr(OFS_CONFIG_THIRD, 8'h00);
        wr(OFS_CONFIG_FOURTH, {6'h00, PIN_FN_TACH});
        fan4_underspeed <= 1'b1;
        idle(2);
        check("alert_n", {7'h00, alert_n}, 8'h00);
        rd(OFS_STATUS_SECOND, 8'h20, "status_fan4");
        wr(OFS_CONFIG_FOURTH, {6'h00, PIN_FN_ALERT});
        idle(0);
        check("shared_oe", {7'h00, shared_pin_oe}, 8'h01);
        fan4_underspeed <= 1'b0;
        rd(OFS_STATUS_SECOND, 8'h20, "status_fan4_last");
        rd(OFS_STATUS_SECOND, 8'h00, "status_fan4_clear");
        idle(2);
        check("shared_oe", {7'h00, shared_pin_oe}, 8'h00);
        $display("test fan4 done");
        results();
    end
endmodule // thermal_pin_timer_and_trip_bench
